// *** ubd_pkg.sv ***
// Shared constants, field layouts and carrier types for the descriptor engine
package ubd_pkg;

	// ==========================================================
	// Memory map
	localparam int unsigned EP_COUNT   = 8;             // Endpoints served
	localparam int unsigned RAM_BYTES  = 512;           // Dual-port RAM size in bytes
	localparam logic [15:0] BDT_BASE   = 16'h2000;      // Table base in linear space
	localparam logic [15:0] ADDR_STEP  = 16'h0001;      // Status of entry n sits one below
	localparam logic [15:0] RAM_ORIGIN = BDT_BASE - ADDR_STEP;
	localparam logic [1:0]  OFS_STAT   = 2'h0;          // Status byte within an entry
	localparam logic [1:0]  OFS_CNT    = 2'h1;          // Count byte within an entry
	localparam logic [1:0]  OFS_ADRL   = 2'h2;          // Buffer address low byte
	localparam logic [1:0]  OFS_ADRH   = 2'h3;          // Buffer address high byte

	// ==========================================================
	// Status byte layout and byte count
	localparam int unsigned CNT_W        = 10;          // Byte count width
	localparam int unsigned MID_TOG_EN   = 1;           // Toggle check enable in mid field
	localparam int unsigned MID_STALL    = 0;           // Stall request in mid field
	localparam int unsigned IDX_W        = 11;          // Byte index, one above count
	localparam logic [10:0] IDX_SAT      = 11'h07FF;    // Byte index saturation

	typedef struct packed {
		logic       engine_owns_buffer; // Ownership semaphore
		logic       expected_toggle;    // DATA0/DATA1 expectation
		logic [3:0] mid;                // Config bits or token_id_field
		logic [1:0] count_hi;           // count_bit_nine, count_bit_eight
	} ubd_status_t;

	// ==========================================================
	// Token and handshake codes
	localparam logic [3:0] TOK_OUT   = 4'h1;
	localparam logic [3:0] TOK_IN    = 4'h9;
	localparam logic [3:0] TOK_SETUP = 4'hD;
	localparam logic [3:0] HS_ACK    = 4'h2;
	localparam logic [3:0] HS_NAK    = 4'hA;
	localparam logic [3:0] HS_STALL  = 4'hE;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic       we;     // Write strobe
		logic [15:0] addr;  // Linear address
		logic [7:0] wdata;  // Write data
	} ubd_core_req_t;

	typedef struct packed {
		logic       valid;  // Token strobe
		logic [3:0] ep;     // Endpoint number
		logic [3:0] token_id_field;    // Token code
	} ubd_token_t;

	typedef struct packed {
		logic       valid;  // Byte strobe
		logic [7:0] data;   // Payload byte
		logic       last;   // Final beat of packet
		logic       empty;  // Beat carries no byte
		logic       data1;  // Packet is DATA1
		logic       err;    // Packet damaged
	} ubd_rx_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
		logic       empty;
	} ubd_tx_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] code;
	} ubd_hs_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOAD,
		ST_DECIDE,
		ST_TX,
		ST_RX,
		ST_WB_CNT,
		ST_WB_STAT
	} ubd_state_t;

endpackage : ubd_pkg

// *** ubd_engine.sv ***
// Buffer descriptor engine with shared dual-port RAM
//
// Contract
// - Entry is status, count, address low, address high; status n at base+4n-1.
// - Descriptor bytes are plain RAM unless the endpoint IN-enable is set.
// - Ownership bit clear: core owns entry; set: engine owns it.
// - Status byte stays readable by core and engine at all times.
// - Engine clears ownership when a transaction completes.
// - Engine writes token id into status and transfer count into count.
// - Toggle mismatch with checking on: ACK, nothing stored, nothing updated.
// - Checking off or matching toggle: ACK, store, release, flag done, update.
// - Stall request set: answer STALL, set stalled flag, raise stall event.
// - Stall keeps ownership and entry, except SETUP clears stall and releases.
// - IN sends count bytes, then writes back bytes actually sent.
// - OUT count is the limit; engine writes back bytes received.
// - OUT packet longer than count: NAK, count left unchanged.
// - Count is ten bits: low eight in count byte, top two in status.
// - Whole RAM except table space is usable as buffer space.
// - Stalled flag stays set until firmware clears it or reset.
`timescale 1ns/100ps

module ubd_engine #(
	parameter  int unsigned NUM_EP    = ubd_pkg::EP_COUNT,   // Endpoints
	parameter  int unsigned RAM_BYTES = ubd_pkg::RAM_BYTES,  // RAM depth
	localparam int unsigned EPW       = $clog2(NUM_EP),
	localparam int unsigned BW        = EPW + 1
) (
	input  wire logic                  i_mclk,          // System clock
	input  wire logic                  i_rst_b,         // Sync reset, active low
	input  wire ubd_pkg::ubd_core_req_t i_core,         // Core RAM access
	output logic [7:0]                 o_core_rdata,    // Core read data, one cycle late
	input  wire logic [NUM_EP-1:0]     i_ep_in_enable,  // endpoint_in_enable per endpoint
	input  wire logic [NUM_EP-1:0]     i_stall_clear,   // Firmware clear of stalled flag
	input  wire ubd_pkg::ubd_token_t   i_token,         // Token from link
	input  wire ubd_pkg::ubd_rx_t      i_rx,            // OUT/SETUP data from link
	input  wire logic                  i_tx_ready,      // Link takes IN byte
	output ubd_pkg::ubd_tx_t           o_tx,            // IN data to link
	output ubd_pkg::ubd_hs_t           o_hs,            // Handshake to link
	output logic [NUM_EP-1:0]          o_ep_stalled,    // endpoint_stalled_flag
	output logic                       o_stall_event,   // Stall issued pulse
	output logic                       o_done,          // transaction_done_flag pulse
	output logic [BW-1:0]              o_done_bd        // Entry of last completion or SETUP stall release
);

	localparam int unsigned AW = $clog2(RAM_BYTES);

	// ==========================================================
	// State
	typedef struct packed {
		ubd_pkg::ubd_state_t  st;
		logic [BW-1:0]        bd;        // Entry in service
		logic [3:0]           tok_pid;   // Token of this transaction
		logic [1:0]           k;         // Entry byte being fetched
		ubd_pkg::ubd_status_t stat;      // Fetched status
		logic [9:0]           cnt;       // Byte count
		logic [15:0]          buf_addr;  // Buffer linear address
		logic [10:0]          idx;       // Byte index in packet
		logic                 match;     // Toggle accepted
		logic                 unstall;   // SETUP release of a stall
		logic [7:0]           rdata;
		ubd_pkg::ubd_tx_t     tx;
		ubd_pkg::ubd_hs_t     hs;
		logic [NUM_EP-1:0]    stalled;
		logic                 stall_evt;
		logic                 done;
		logic [BW-1:0]        done_bd;
	} ubd_regs_t;

	ubd_regs_t  s_reg;
	ubd_regs_t  s_next;
	logic [7:0] ram [RAM_BYTES];

	logic [15:0]     core_off;
	logic            core_hit;
	logic [AW-1:0]   core_idx;
	logic [AW-1:0]   eng_raddr;
	logic [7:0]      eng_rbyte;
	logic            eng_we;
	logic [AW-1:0]   eng_waddr;
	logic [7:0]      eng_wdata;
	logic [AW-1:0]   entry_base;
	logic [AW-1:0]   buf_idx;
	logic [BW-1:0]   tok_bd;
	logic            tok_ok;
	logic [EPW-1:0]  cur_ep;
	logic            tog_ok;
	logic [10:0]     rx_total;
	ubd_pkg::ubd_status_t wb_stat;

	// ==========================================================
	// Address translation: linear space to RAM index
	// Out-of-range core reads return zero and writes are dropped
	assign core_off   = i_core.addr - ubd_pkg::RAM_ORIGIN;
	assign core_hit   = core_off < 16'(RAM_BYTES);
	assign core_idx   = core_off[AW-1:0];
	assign entry_base = AW'({s_reg.bd, 2'b00});
	assign buf_idx    = AW'(s_reg.buf_addr - ubd_pkg::RAM_ORIGIN + 16'(s_reg.idx));
	assign tok_bd     = {i_token.ep[EPW-1:0], i_token.token_id_field == ubd_pkg::TOK_IN};
	assign cur_ep     = s_reg.bd[BW-1:1];
	assign eng_rbyte  = ram[eng_raddr];

	// ==========================================================
	// Token acceptance and packet checks
	// Endpoint must exist and be enabled before its entry means anything
	assign tok_ok = (32'(i_token.ep) < NUM_EP)
		&& i_ep_in_enable[i_token.ep[EPW-1:0]]
		&& (i_token.token_id_field == ubd_pkg::TOK_OUT || i_token.token_id_field == ubd_pkg::TOK_IN
			|| i_token.token_id_field == ubd_pkg::TOK_SETUP);

	// Toggle acceptance, decided on the first beat of a packet
	assign tog_ok = (s_reg.idx == 11'h0000)
		? (!s_reg.stat.mid[ubd_pkg::MID_TOG_EN]
			|| (i_rx.data1 == s_reg.stat.expected_toggle))
		: s_reg.match;

	// Bytes seen once this beat is counted
	assign rx_total = (i_rx.empty || s_reg.idx == ubd_pkg::IDX_SAT)
		? s_reg.idx : s_reg.idx + 11'h0001;

	// ==========================================================
	// Write-back image
	// Status image written back at the end of a transaction
	always_comb begin
		wb_stat = s_reg.stat;
		wb_stat.engine_owns_buffer = 1'b0;
		if (s_reg.unstall) begin
			wb_stat.mid[ubd_pkg::MID_STALL] = 1'b0;
		end else begin
			wb_stat.mid      = s_reg.tok_pid;
			wb_stat.count_hi = s_reg.cnt[9:8];
		end
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		s_next           = s_reg;
		s_next.hs.valid  = 1'b0;
		s_next.stall_evt = 1'b0;
		s_next.done      = 1'b0;
		s_next.rdata     = core_hit ? ram[core_idx] : 8'h00;
		s_next.stalled   = s_reg.stalled & ~i_stall_clear;
		eng_we    = 1'b0;
		eng_waddr = entry_base;
		eng_wdata = 8'h00;
		eng_raddr = entry_base | AW'(s_reg.k);
		unique case (s_reg.st)
			ubd_pkg::ST_IDLE: begin
				// Disabled endpoints leave their entry as ordinary RAM
				// Tokens arriving while busy are dropped; the host retries
				if (i_token.valid && tok_ok) begin
					s_next.bd      = tok_bd;
					s_next.tok_pid = i_token.token_id_field;
					s_next.k       = ubd_pkg::OFS_STAT;
					s_next.idx     = 11'h0000;
					s_next.match   = 1'b1;
					s_next.unstall = 1'b0;
					s_next.st      = ubd_pkg::ST_LOAD;
				end
			end
			ubd_pkg::ST_LOAD: begin
				// Fetch the four entry bytes in order
				unique case (s_reg.k)
					ubd_pkg::OFS_STAT: begin
						s_next.stat     = eng_rbyte;
						s_next.cnt[9:8] = eng_rbyte[1:0];
					end
					ubd_pkg::OFS_CNT:  s_next.cnt[7:0]       = eng_rbyte;
					ubd_pkg::OFS_ADRL: s_next.buf_addr[7:0]  = eng_rbyte;
					ubd_pkg::OFS_ADRH: begin
						s_next.buf_addr[15:8] = eng_rbyte;
						s_next.st             = ubd_pkg::ST_DECIDE;
					end
				endcase
				s_next.k = s_reg.k + 2'h1;
			end
			ubd_pkg::ST_DECIDE: begin
				if (!s_reg.stat.engine_owns_buffer) begin
					// Core still owns the entry: nothing is touched
					s_next.hs = '{valid: 1'b1, code: ubd_pkg::HS_NAK};
					s_next.st = ubd_pkg::ST_IDLE;
				end else if (s_reg.stat.mid[ubd_pkg::MID_STALL]) begin
					// Only SETUP lifts a buffer stall; other tokens keep it
					if (s_reg.tok_pid == ubd_pkg::TOK_SETUP) begin
						s_next.unstall = 1'b1;
						s_next.hs      = '{valid: 1'b1, code: ubd_pkg::HS_NAK};
						s_next.st      = ubd_pkg::ST_WB_STAT;
					end else begin
						s_next.hs              = '{valid: 1'b1, code: ubd_pkg::HS_STALL};
						s_next.stalled[cur_ep] = 1'b1;
						s_next.stall_evt       = 1'b1;
						s_next.st              = ubd_pkg::ST_IDLE;
					end
				end else if (s_reg.tok_pid == ubd_pkg::TOK_IN) begin
					s_next.st = ubd_pkg::ST_TX;
				end else begin
					s_next.st = ubd_pkg::ST_RX;
				end
			end
			ubd_pkg::ST_TX: begin
				// Present count bytes from the buffer, one per accepted beat
				// A zero count still sends one empty beat marked last
				eng_raddr = buf_idx;
				if (!s_reg.tx.valid || i_tx_ready) begin
					if (s_reg.tx.valid && s_reg.tx.last) begin
						s_next.tx.valid = 1'b0;
						s_next.cnt      = s_reg.idx[9:0];
						s_next.st       = ubd_pkg::ST_WB_CNT;
					end else begin
						s_next.tx.valid = 1'b1;
						s_next.tx.data  = eng_rbyte;
						s_next.tx.empty = (s_reg.cnt == 10'h000);
						s_next.tx.last  = (s_reg.idx + 11'h0001 >= {1'b0, s_reg.cnt})
							|| (s_reg.cnt == 10'h000);
						if (s_reg.cnt != 10'h000) begin
							s_next.idx = s_reg.idx + 11'h0001;
						end
					end
				end
			end
			ubd_pkg::ST_RX: begin
				// Store accepted bytes up to the count limit
				// Bytes past the limit are still counted, so an oversize packet is seen
				eng_waddr = buf_idx;
				eng_wdata = i_rx.data;
				if (i_rx.valid) begin
					s_next.match = tog_ok;
					eng_we = !i_rx.empty && tog_ok
						&& (s_reg.idx < {1'b0, s_reg.cnt});
					s_next.idx = rx_total;
					if (i_rx.last) begin
						s_next.st = ubd_pkg::ST_IDLE;
						if (i_rx.err || rx_total > {1'b0, s_reg.cnt}) begin
							s_next.hs = '{valid: 1'b1, code: ubd_pkg::HS_NAK};
						end else if (!tog_ok) begin
							s_next.hs = '{valid: 1'b1, code: ubd_pkg::HS_ACK};
						end else begin
							s_next.hs  = '{valid: 1'b1, code: ubd_pkg::HS_ACK};
							s_next.cnt = rx_total[9:0];
							s_next.st  = ubd_pkg::ST_WB_CNT;
						end
					end
				end
			end
			ubd_pkg::ST_WB_CNT: begin
				// Low eight bits of the transfer count
				eng_we    = 1'b1;
				eng_waddr = entry_base | AW'(ubd_pkg::OFS_CNT);
				eng_wdata = s_reg.cnt[7:0];
				s_next.st = ubd_pkg::ST_WB_STAT;
			end
			ubd_pkg::ST_WB_STAT: begin
				// Status last, which hands the entry back to the core
				// Count went first except on a SETUP release, so a released entry never shows a stale count
				eng_we         = 1'b1;
				eng_waddr      = entry_base | AW'(ubd_pkg::OFS_STAT);
				eng_wdata      = wb_stat;
				s_next.done    = !s_reg.unstall;
				s_next.done_bd = s_reg.bd;
				s_next.st      = ubd_pkg::ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register
	// Reset leaves the engine idle with every output low
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Shared memory
	// Dual-port RAM, contents undefined after reset
	// No reset on the array: firmware sets up each entry before use
	always_ff @(posedge i_mclk) begin
		if (i_core.we && core_hit) begin
			ram[core_idx] <= i_core.wdata;
		end
		if (eng_we) begin
			ram[eng_waddr] <= eng_wdata;
		end
	end

	// ==========================================================
	// Outputs
	// Outputs straight from state flops
	assign o_core_rdata  = s_reg.rdata;
	assign o_tx          = s_reg.tx;
	assign o_hs          = s_reg.hs;
	assign o_ep_stalled  = s_reg.stalled;
	assign o_stall_event = s_reg.stall_evt;
	assign o_done        = s_reg.done;
	assign o_done_bd     = s_reg.done_bd;

endmodule : ubd_engine

// *** ubd_engine_asserts.sv ***
// Port checks for the descriptor engine
`timescale 1ns/100ps
module ubd_engine_asserts #(
	parameter int unsigned NUM_EP = 8   // Endpoints
) (
	input wire logic                    i_mclk,        // Clock
	input wire logic                    i_rst_b,       // Reset, active low
	input wire ubd_pkg::ubd_token_t     i_token,       // Token
	input wire logic [NUM_EP-1:0]       i_stall_clear, // Flag clear
	input wire logic                    i_tx_ready,    // Sink ready
	input wire ubd_pkg::ubd_tx_t        o_tx,          // IN beats
	input wire ubd_pkg::ubd_hs_t        o_hs,          // Handshake
	input wire logic [NUM_EP-1:0]       o_ep_stalled,  // Stalled flags
	input wire logic                    o_stall_event, // Stall pulse
	input wire logic                    o_done,        // Completion
	input wire logic [$clog2(NUM_EP):0] o_done_bd      // Entry index
);
	// ==========================================
	// Clocking and steps
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);
	sequence s_nak;
		o_hs.valid && o_hs.code == ubd_pkg::HS_NAK;
	endsequence
	sequence s_in_last;
		o_tx.valid && o_tx.last && i_tx_ready;
	endsequence
	// ==========================================
	// Stall handling
	a_stall_code: assert property (o_stall_event |-> o_hs.valid && o_hs.code == ubd_pkg::HS_STALL
		&& o_ep_stalled != '0) else $error("stall event without STALL and flag");
	a_stall_delay: assert property (o_hs.valid && o_hs.code == ubd_pkg::HS_STALL
		|-> $past(i_token.valid, 6)) else $error("STALL not six cycles after token");
	a_stall_rise: assert property ((o_ep_stalled & ~$past(o_ep_stalled)) != '0
		|-> o_stall_event) else $error("stalled flag set without stall");
	a_stall_sticky: assert property (o_ep_stalled != '0 |=>
		(($past(o_ep_stalled) & ~$past(i_stall_clear)) & ~o_ep_stalled) == '0)
		else $error("stalled flag dropped without clear");
	// ==========================================
	// Completion and data
	a_out_done: assert property (o_done && !o_done_bd[0] |->
		$past(o_hs.valid && o_hs.code == ubd_pkg::HS_ACK, 2))
		else $error("OUT completion without ACK");
	a_nak_quiet: assert property (s_nak |=> !o_done [*3])
		else $error("completion after NAK");
	a_tx_hold: assert property (o_tx.valid && !i_tx_ready |=> $stable(o_tx))
		else $error("IN beat changed while stalled");
	a_in_done: assert property (s_in_last |-> ##[1:6] (o_done && o_done_bd[0]))
		else $error("IN completion missing");
endmodule : ubd_engine_asserts

bind ubd_engine ubd_engine_asserts #(.NUM_EP(NUM_EP)) i_chk (.i_mclk, .i_rst_b, .i_token,
	.i_stall_clear, .i_tx_ready, .o_tx, .o_hs, .o_ep_stalled, .o_stall_event, .o_done, .o_done_bd);

// *** ubd_host_model.sv ***
// Link-side host model: tokens, OUT data, IN sink
`timescale 1ns/100ps
module ubd_host_model (
	input  wire logic             i_mclk,     // Clock
	input  wire logic             i_slow,     // Stall IN beats
	output ubd_pkg::ubd_token_t   o_token,    // Token
	output ubd_pkg::ubd_rx_t      o_rx,       // OUT beats
	output logic                  o_tx_ready, // Takes IN beat
	input  wire ubd_pkg::ubd_tx_t i_tx,       // IN beats
	input  wire ubd_pkg::ubd_hs_t i_hs        // Handshake
);
	logic [3:0] hs_code;
	int         hs_cnt = 0;
	int         tx_cnt = 0;
	logic [7:0] tx_seen [0:1];
	logic       ph = 1'b0;
	initial o_token = '0;
	initial o_rx = '0;
	// Ready every other cycle when slow
	always @(posedge i_mclk) ph <= ~ph;
	assign o_tx_ready = ~i_slow | ph;
	// Record handshakes and taken IN beats
	always @(posedge i_mclk) begin
		if (i_hs.valid === 1'b1) begin
			hs_code <= i_hs.code;
			hs_cnt  <= hs_cnt + 1;
		end
		if (i_tx.valid === 1'b1 && o_tx_ready) begin
			if (tx_cnt < 2) tx_seen[tx_cnt] <= i_tx.data;
			tx_cnt <= tx_cnt + 1;
		end
	end
	task automatic send_token(input logic [3:0] ep, input logic [3:0] token_id_field);
		@(posedge i_mclk) #1;
		o_token = '{1'b1, ep, token_id_field};
		@(posedge i_mclk) #1;
		o_token.valid = 1'b0;
	endtask : send_token
	// Beats start once the engine has fetched the entry
	task automatic send_data(input int n, input logic d1, input logic [7:0] b0);
		repeat (6) @(posedge i_mclk);
		#1;
		for (int k = 0; k < n; k++) begin
			o_rx = '{1'b1, b0 + 8'(k), k == n - 1, 1'b0, d1, 1'b0};
			@(posedge i_mclk) #1;
		end
		o_rx.valid = 1'b0;
		o_rx.data  = ~o_rx.data;   // Released line shows no stale byte
	endtask : send_data
endmodule : ubd_host_model

// *** tb_top.sv ***
// Self-checking bench for the descriptor engine
`timescale 1ns/100ps
module tb_top;
	logic                   clk = 1'b0;
	logic                   rst_b = 1'b0;
	ubd_pkg::ubd_core_req_t core = '0;
	logic [7:0]             ep_en = 8'h00;
	logic [7:0]             st_clr = 8'h00;
	logic                   slow = 1'b0;
	ubd_pkg::ubd_token_t    tok_w;
	ubd_pkg::ubd_rx_t       rx_w;
	ubd_pkg::ubd_tx_t       tx_w;
	ubd_pkg::ubd_hs_t       hs_w;
	logic                   rdy_w, stall_ev, done;
	logic [7:0]             rdata, stalled;
	logic [3:0]             done_bd;
	int failures = 0;
	int checks_done = 0;
	int done_cnt = 0;
	int stall_cnt = 0;
	int hs_base = 0;
	int cycles = 0;
	initial forever #5 clk = ~clk;
	ubd_engine i_dut (.i_mclk(clk), .i_rst_b(rst_b), .i_core(core), .o_core_rdata(rdata),
		.i_ep_in_enable(ep_en), .i_stall_clear(st_clr), .i_token(tok_w), .i_rx(rx_w),
		.i_tx_ready(rdy_w), .o_tx(tx_w), .o_hs(hs_w), .o_ep_stalled(stalled),
		.o_stall_event(stall_ev), .o_done(done), .o_done_bd(done_bd));
	ubd_host_model host (.i_mclk(clk), .i_slow(slow), .o_token(tok_w), .o_rx(rx_w),
		.o_tx_ready(rdy_w), .i_tx(tx_w), .i_hs(hs_w));
	// Completion count and hang guard
	always @(posedge clk) begin
		cycles++;
		if (done === 1'b1) done_cnt++;
		if (stall_ev === 1'b1) stall_cnt++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	function automatic logic [15:0] sa(input int n);
		return ubd_pkg::BDT_BASE + 16'(4 * n) - 16'h0001;
	endfunction : sa
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		core = '{1'b1, a, d};
		@(posedge clk) #1;
		core.we = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk) #1;
		core.addr = a;
		@(posedge clk) #1;
		chk($sformatf("ram %h", a), 16'(exp), 16'(rdata));
	endtask : rd
	// Count, address, then status last
	task automatic arm(input int n, input logic [7:0] s, c, input logic [15:0] ad);
		wr(sa(n) + 16'h0001, c);
		wr(sa(n) + 16'h0002, ad[7:0]);
		wr(sa(n) + 16'h0003, ad[15:8]);
		wr(sa(n), s);
	endtask : arm
	task automatic tok(input logic [3:0] ep, token_id_field);
		hs_base = host.hs_cnt;
		host.send_token(ep, token_id_field);
	endtask : tok
	task automatic hs_wait(input logic [3:0] code);
		for (int k = 0; k < 60 && host.hs_cnt == hs_base; k++) @(posedge clk);
		repeat (4) @(posedge clk);
		#1;
		chk("handshake", {12'h001, code}, {12'(host.hs_cnt - hs_base), host.hs_code});
	endtask : hs_wait
	// ==========================================
	// Test sequence
	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk("idle outputs", 16'h0000, {5'h00, hs_w.valid, done, stall_ev, stalled});
		wr(sa(14), 8'h5A);
		rd(sa(14), 8'h5A);
		// OUT, checking off: stored, released, reported
		arm(2, 8'h80, 8'h08, 16'h2100);
		ep_en = 8'h0F;
		tok(4'h1, ubd_pkg::TOK_OUT);
		host.send_data(3, 1'b0, 8'h30);
		hs_wait(ubd_pkg::HS_ACK);
		chk("done entry", 16'h0102, {8'(done_cnt), 4'h0, done_bd});
		rd(sa(2), 8'h04);
		rd(sa(2) + 16'h0001, 8'h03);
		rd(16'h2102, 8'h32);
		// Toggle mismatch dropped, then match taken
		wr(16'h2110, 8'hEE);
		arm(4, 8'h88, 8'h08, 16'h2110);
		tok(4'h2, ubd_pkg::TOK_OUT);
		host.send_data(2, 1'b1, 8'h40);
		hs_wait(ubd_pkg::HS_ACK);
		chk("done count", 16'h0001, 16'(done_cnt));
		rd(sa(4), 8'h88);
		rd(16'h2110, 8'hEE);
		tok(4'h2, ubd_pkg::TOK_OUT);
		host.send_data(2, 1'b0, 8'h40);
		hs_wait(ubd_pkg::HS_ACK);
		chk("done entry", 16'h0204, {8'(done_cnt), 4'h0, done_bd});
		rd(sa(4), 8'h04);
		rd(16'h2111, 8'h41);
		// Oversized packet, core-owned entry, disabled endpoint
		arm(6, 8'h80, 8'h02, 16'h2120);
		tok(4'h3, ubd_pkg::TOK_OUT);
		host.send_data(3, 1'b0, 8'h50);
		hs_wait(ubd_pkg::HS_NAK);
		rd(sa(6), 8'h80);
		rd(sa(6) + 16'h0001, 8'h02);
		chk("done count", 16'h0002, 16'(done_cnt));
		tok(4'h1, ubd_pkg::TOK_OUT);
		hs_wait(ubd_pkg::HS_NAK);
		tok(4'h5, ubd_pkg::TOK_OUT);
		repeat (20) @(posedge clk) #1;
		chk("silent", 16'h0000, 16'(host.hs_cnt - hs_base));
		// Ten-bit IN count with a slow sink
		// Whole IN buffer written while the core owns it, so no unknown byte goes out
		for (int k = 0; k < 257; k++) wr(16'h2040 + 16'(k), 8'hA0 + 8'(k));
		arm(5, 8'h81, 8'h01, 16'h2040);
		slow = 1'b1;
		tok(4'h2, ubd_pkg::TOK_IN);
		for (int k = 0; k < 1200 && done_cnt < 3; k++) @(posedge clk);
		repeat (4) @(posedge clk) #1;
		chk("in beats", 16'h0101, 16'(host.tx_cnt));
		chk("in bytes", 16'hA0A1, {host.tx_seen[0], host.tx_seen[1]});
		chk("in entry", 16'h0005, 16'(done_bd));
		rd(sa(5), 8'h25);
		rd(sa(5) + 16'h0001, 8'h01);
		// Stall answers and sticks; SETUP releases
		arm(6, 8'h84, 8'h02, 16'h2120);
		tok(4'h3, ubd_pkg::TOK_OUT);
		hs_wait(ubd_pkg::HS_STALL);
		chk("stall events", 16'h0001, 16'(stall_cnt));
		repeat (10) @(posedge clk);
		chk("stalled", 16'h0008, 16'(stalled));
		rd(sa(6), 8'h84);
		st_clr = 8'h08;
		@(posedge clk) #1;
		st_clr = 8'h00;
		chk("stall cleared", 16'h0000, 16'(stalled));
		tok(4'h3, ubd_pkg::TOK_SETUP);
		hs_wait(ubd_pkg::HS_NAK);
		rd(sa(6), 8'h00);
		final_report();
	end
endmodule : tb_top
